/* File: verilog/crb_pkg.sv */
// Contract
// - capture only on the clock crossing edge
// - width strap: low 25x1:1, high 14x1:2
// - bank strap picks register-A or register-B assignment
// - wide mode drives three spare terminals low
// - active-low reset clears everything without clock
// - reset ignores undriven data, clock, reference inputs
// - outputs stay low after reset while inputs low
// - both selects high freeze the gated outputs
// - reset overrides chip-select gating
// - narrow mode drives identical A and B copies
// - control inputs 1,4,7 or 14,11,7 by mode
// - enable, termination, module select never frozen
package crb_pkg;

    localparam int CRB_DATA_W = 25;
    localparam int CRB_ROWS = 14;
    localparam int CRB_FIFO_DEPTH = 8;

    // input positions (zero based) of the ungated controls
    localparam int CRB_CKE_A_IDX = 0;
    localparam int CRB_ODT_A_IDX = 3;
    localparam int CRB_CS_IDX = 6;
    localparam int CRB_CKE_B_IDX = 13;
    localparam int CRB_ODT_B_IDX = 10;

    // spare terminal rows of the second output column in wide mode
    localparam int CRB_SPARE_ROW0 = 0;
    localparam int CRB_SPARE_ROW1 = 3;
    localparam int CRB_SPARE_ROW2 = 6;

    localparam logic [13:0] CRB_PIN_RST = 14'h0000;

    typedef enum logic [1:0] {
        CRB_WIDE = 2'b00,
        CRB_NARROW_A = 2'b01,
        CRB_NARROW_B = 2'b11
    } crb_mode_t;

    typedef struct packed {
        logic csr_n;
        logic [CRB_DATA_W-1:0] d;
    } crb_word_t;

    typedef struct packed {
        logic [CRB_ROWS-1:0] a;
        logic [CRB_ROWS-1:0] b;
    } crb_pins_t;

    // outputs that chip-select gating never freezes
    function automatic logic crb_ungated(input crb_mode_t mode, input int idx);
        if (mode == CRB_NARROW_B) begin
            return (idx == CRB_CKE_B_IDX) || (idx == CRB_ODT_B_IDX) || (idx == CRB_CS_IDX);
        end
        return (idx == CRB_CKE_A_IDX) || (idx == CRB_ODT_A_IDX) || (idx == CRB_CS_IDX);
    endfunction

    // input index feeding second-column row in wide mode, -1 for spare
    function automatic int crb_wide_b_idx(input int row);
        if (row == CRB_SPARE_ROW0 || row == CRB_SPARE_ROW1 || row == CRB_SPARE_ROW2) begin
            return -1;
        end
        if (row < CRB_SPARE_ROW1) begin
            return row + 13;
        end
        if (row < CRB_SPARE_ROW2) begin
            return row + 12;
        end
        return row + 11;
    endfunction

endpackage

/* File: verilog/crb_buffer.sv */
`timescale 1ns/1ps

module crb_fifo #(
    parameter int W = 26,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,            // system clock
    input wire logic i_sys_rst,        // synchronous reset, high
    input wire logic i_reset_n,        // asynchronous reset, low
    input wire logic [W-1:0] i_data,   // fill-side word
    input wire logic i_valid,          // fill-side valid
    output logic o_ready,              // fill-side ready
    output logic [W-1:0] o_data,       // drain-side word
    output logic o_valid,              // drain-side valid
    input wire logic i_ready           // drain-side ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic rdy;
    } crb_fifo_st_t;

    crb_fifo_st_t s_q, s_d;
    logic push, pop;

    assign o_valid = (s_q.cnt != '0);
    assign o_data = s_q.mem[s_q.rd];
    assign o_ready = s_q.rdy;
    assign push = i_valid && s_q.rdy;
    assign pop = o_valid && i_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = i_data;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        s_d.rdy = (s_d.cnt != (AW + 1)'(DEPTH));
    end

    // ready stays low in reset so floating inputs are never taken
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n || i_sys_rst);

    // occupancy and ordering of the held words
    AST_FIFO_BOUND: assert property (
        (s_q.cnt <= (AW + 1)'(DEPTH)))
        else $error("fifo count beyond its depth");

    AST_FIFO_FULL_STOP: assert property (
        s_q.cnt == (AW + 1)'(DEPTH)
        |-> !o_ready)
        else $error("fifo offers room while full");

    AST_FIFO_PUSH_COUNT: assert property (
        push && !pop
        |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
        else $error("fifo count did not rise on a push");

    AST_FIFO_POP_COUNT: assert property (
        pop && !push
        |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
        else $error("fifo count did not fall on a pop");

    AST_FIFO_BOTH_COUNT: assert property (
        push && pop
        |=> $stable(s_q.cnt))
        else $error("fifo count moved on push with pop");

    AST_FIFO_FIRST_WORD: assert property (
        push && !o_valid
        |=> (o_valid && o_data == $past(i_data)))
        else $error("fifo head is not the word pushed into it when empty");

    AST_FIFO_HEAD_HOLD: assert property (
        o_valid && !i_ready
        |=> (o_valid && $stable(o_data)))
        else $error("fifo head changed without a pop");

    AST_FIFO_NO_TAKE_FULL: assert property (
        i_valid && !o_ready && !i_ready
        |=> $stable(s_q.cnt))
        else $error("fifo took a word while full");

    AST_FIFO_DRAIN: assert property (
        pop && !push && s_q.cnt == (AW + 1)'(1)
        |=> !o_valid)
        else $error("fifo still valid after last word left");

    AST_FIFO_READY_RELEASE: assert property (disable iff (!i_reset_n)
        $fell(i_sys_rst)
        |-> (!o_ready ##1 o_ready))
        else $error("fifo ready wrong after reset release");
endmodule

module crb_buffer
    import crb_pkg::*;
(
    input wire logic i_clk,                      // capture clock, 100 ns
    input wire logic i_sys_rst,                  // synchronous reset, high
    input wire logic i_reset_n,                  // asynchronous reset, low
    input wire logic i_width_select_strap,       // low 1:1, high 1:2
    input wire logic i_bank_select_strap,        // low register A, high B
    input wire logic [CRB_DATA_W-1:0] i_data,    // data inputs 1..25
    input wire logic i_register_chip_select_n,   // second chip select
    input wire logic i_in_valid,                 // input word offered
    output logic o_in_ready,                     // input word accepted
    input wire logic i_out_ready,                // capture edge enable
    output logic [CRB_ROWS-1:0] o_pin_a,         // first output column
    output logic [CRB_ROWS-1:0] o_pin_b          // second output column
);
    crb_pins_t s_q, s_d;
    crb_word_t in_word, cap_word;
    crb_mode_t mode;
    logic cap_valid, pop, freeze;

    assign in_word.csr_n = i_register_chip_select_n;
    assign in_word.d = i_data;
    assign pop = cap_valid && i_out_ready;

    crb_fifo #(.W($bits(crb_word_t)), .DEPTH(CRB_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_reset_n(i_reset_n),
        .i_data(in_word),
        .i_valid(i_in_valid),
        .o_ready(o_in_ready),
        .o_data(cap_word),
        .o_valid(cap_valid),
        .i_ready(i_out_ready)
    );

    always_comb begin
        if (!i_width_select_strap) begin
            mode = CRB_WIDE;
        end else if (i_bank_select_strap) begin
            mode = CRB_NARROW_B;
        end else begin
            mode = CRB_NARROW_A;
        end
    end

    // both selects deselected (high) hold the gated outputs
    assign freeze = cap_word.d[CRB_CS_IDX] && cap_word.csr_n;

    always_comb begin
        int bi;
        bi = 0;
        s_d = s_q;
        if (pop) begin
            for (int r = 0; r < CRB_ROWS; r++) begin
                if (crb_ungated(mode, r) || !freeze) begin
                    s_d.a[r] = cap_word.d[r];
                end
                if (mode == CRB_WIDE) begin
                    bi = crb_wide_b_idx(r);
                    if (bi < 0) begin
                        s_d.b[r] = 1'b0;
                    end else if (crb_ungated(mode, bi) || !freeze) begin
                        s_d.b[r] = cap_word.d[bi];
                    end
                end else if (crb_ungated(mode, r) || !freeze) begin
                    s_d.b[r] = cap_word.d[r];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= {CRB_PIN_RST, CRB_PIN_RST};
        end else if (i_sys_rst) begin
            s_q <= {CRB_PIN_RST, CRB_PIN_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_pin_a = s_q.a;
    assign o_pin_b = s_q.b;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n || i_sys_rst);

    AST_ASYNC_CLEAR: assert property (disable iff (1'b0)
        !i_reset_n |-> (o_pin_a == '0 && o_pin_b == '0))
        else $error("outputs not low during asynchronous reset");

    AST_SYNC_CLEAR: assert property (disable iff (!i_reset_n)
        i_sys_rst |=> (o_pin_a == '0 && o_pin_b == '0 && !o_in_ready))
        else $error("reset did not clear outputs despite gating");

    AST_QUIET_AFTER_RESET: assert property (disable iff (!i_reset_n)
        $fell(i_sys_rst) ##0 !pop [*2] |-> (o_pin_a == '0 && o_pin_b == '0))
        else $error("output moved after reset without a capture");

    AST_HOLD_NO_CAPTURE: assert property (
        !pop |=> ($stable(o_pin_a) && $stable(o_pin_b)))
        else $error("output changed without a capture edge");

    AST_WIDE_PASS: assert property (
        pop && mode == CRB_WIDE && !freeze |=> o_pin_a == $past(cap_word.d[CRB_ROWS-1:0]))
        else $error("wide mode output does not follow input");

    AST_SPARE_LOW: assert property (
        pop && mode == CRB_WIDE |=> (o_pin_b[CRB_SPARE_ROW0] == 1'b0
            && o_pin_b[CRB_SPARE_ROW1] == 1'b0 && o_pin_b[CRB_SPARE_ROW2] == 1'b0))
        else $error("spare terminal not low in wide mode");

    AST_COPIES_EQUAL: assert property (
        pop && mode != CRB_WIDE && !freeze |=> (o_pin_a == o_pin_b
            && o_pin_a == $past(cap_word.d[CRB_ROWS-1:0])))
        else $error("narrow mode copies differ");

    AST_FREEZE_GATED: assert property (
        pop && freeze && mode == CRB_NARROW_A |=> $stable(o_pin_a[1]) && $stable(o_pin_b[13]))
        else $error("gated output changed while both selects high");

    AST_B_CONTROLS: assert property (
        pop && freeze && mode == CRB_NARROW_B |=> (o_pin_a[CRB_CKE_B_IDX]
            == $past(cap_word.d[CRB_CKE_B_IDX]) && o_pin_b[CRB_ODT_B_IDX]
            == $past(cap_word.d[CRB_ODT_B_IDX]) && $stable(o_pin_a[0])))
        else $error("register-B control assignment wrong");

    AST_A_CONTROLS: assert property (
        pop && freeze && mode != CRB_NARROW_B |=> (o_pin_a[CRB_CKE_A_IDX]
            == $past(cap_word.d[CRB_CKE_A_IDX]) && o_pin_a[CRB_CS_IDX]
            == $past(cap_word.d[CRB_CS_IDX])))
        else $error("ungated control was frozen");

    COV_WIDE: cover property (pop && mode == CRB_WIDE && !freeze);
    COV_FREEZE_B: cover property (pop && freeze && mode == CRB_NARROW_B);
    COV_FULL: cover property (!o_in_ready ##1 pop);
    COV_NARROW_A: cover property (pop && mode == CRB_NARROW_A ##1 pop);
    COV_SYNC_GATE: cover property (disable iff (!i_reset_n) i_sys_rst && cap_valid && freeze);

    // mapping and gating of the output columns
    AST_RESET_OVER_GATE: assert property (disable iff (!i_reset_n)
        i_sys_rst && cap_valid && freeze
        |=> (o_pin_a == '0 && o_pin_b == '0))
        else $error("gating held outputs through reset");

    AST_B_GATED_ROWS: assert property (
        pop && freeze && mode == CRB_NARROW_B
        |=> ($stable(o_pin_a[3]) && $stable(o_pin_b[0])))
        else $error("register-B gated row changed while both selects high");

    AST_WIDE_B_PASS: assert property (
        pop && mode == CRB_WIDE && !freeze
        |=> o_pin_b == {$past(cap_word.d[24:18]), 1'b0, $past(cap_word.d[17:16]),
            1'b0, $past(cap_word.d[15:14]), 1'b0})
        else $error("wide mode second column does not follow input");

    AST_WIDE_B_FREEZE: assert property (
        pop && mode == CRB_WIDE && freeze
        |=> $stable(o_pin_b))
        else $error("wide mode second column changed while both selects high");

    AST_SELECT_LIVE: assert property (
        pop
        |=> o_pin_a[CRB_CS_IDX] == $past(cap_word.d[CRB_CS_IDX]))
        else $error("module select output did not follow its input");

    AST_A_COPY_CONTROLS: assert property (
        pop && freeze && mode == CRB_NARROW_A
        |=> (o_pin_b[CRB_CKE_A_IDX] == $past(cap_word.d[CRB_CKE_A_IDX])
            && o_pin_b[CRB_ODT_A_IDX] == $past(cap_word.d[CRB_ODT_A_IDX])))
        else $error("register-A control copy frozen");

    AST_B_COPY_CONTROLS: assert property (
        pop && mode == CRB_NARROW_B
        |=> (o_pin_b[CRB_CKE_B_IDX] == $past(cap_word.d[CRB_CKE_B_IDX])
            && o_pin_b[CRB_CS_IDX] == $past(cap_word.d[CRB_CS_IDX])))
        else $error("register-B control copy wrong");

    AST_WIDE_GATED_ROWS: assert property (
        pop && freeze && mode == CRB_WIDE
        |=> ($stable(o_pin_a[1]) && $stable(o_pin_a[CRB_ROWS-1])
            && o_pin_a[CRB_ODT_A_IDX] == $past(cap_word.d[CRB_ODT_A_IDX])))
        else $error("wide mode gating wrong while both selects high");

    AST_NARROW_B_COPY: assert property (
        pop && !freeze && mode == CRB_NARROW_B
        |=> o_pin_b == $past(cap_word.d[CRB_ROWS-1:0]))
        else $error("register-B copy column does not follow input");

    AST_A_GATED_ROWS: assert property (
        pop && freeze && mode == CRB_NARROW_A
        |=> ($stable(o_pin_a[2]) && $stable(o_pin_b[12])))
        else $error("register-A gated row changed while both selects high");
endmodule

/* File: verif/crb_ctrl_model.sv */
`timescale 1ns/1ps

module crb_ctrl_model
    import crb_pkg::*;
(
    input wire logic i_clk,                 // capture clock
    input wire logic i_in_ready,            // buffer takes word
    output logic [CRB_DATA_W-1:0] o_data,   // data inputs
    output logic o_csr_n,                   // register chip select
    output logic o_valid                    // word offered
);
    initial begin
        o_data = '0;
        o_csr_n = 1'b0;
        o_valid = 1'b0;
    end

    // hold the word until a rising edge sees ready
    task automatic send(input logic [CRB_DATA_W-1:0] d, input logic c, output bit ok);
        int n;
        @(negedge i_clk);
        o_data = d;
        o_csr_n = c;
        o_valid = 1'b1;
        ok = 1'b0;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge i_clk);
            ok = i_in_ready;
        end
    endtask

    // released lines show the inverse of the last value
    task automatic idle();
        @(negedge i_clk);
        o_valid = 1'b0;
        o_data = ~o_data;
        o_csr_n = ~o_csr_n;
    endtask

    // lines kept low around reset release
    task automatic quiet();
        @(negedge i_clk);
        o_valid = 1'b0;
        o_data = '0;
        o_csr_n = 1'b0;
    endtask

    // floating inputs stand-in, module select high so a held word is gated
    task automatic junk();
        @(negedge i_clk);
        o_valid = 1'b1;
        o_data = CRB_DATA_W'($urandom) | 25'h0000040;
        o_csr_n = 1'b1;
    endtask
endmodule

/* File: verif/test_configurable_registered_buffer.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module test_configurable_registered_buffer;
    import crb_pkg::*;
    logic i_clk, i_sys_rst, i_reset_n, i_width_select_strap, i_bank_select_strap;
    logic i_register_chip_select_n, i_in_valid, o_in_ready, i_out_ready;
    logic [CRB_DATA_W-1:0] i_data;
    logic [CRB_ROWS-1:0] o_pin_a, o_pin_b;
    int miscompares, checks, cnt, cyc;
    bit ok, p;
    crb_pins_t exp_q[$];
    crb_pins_t prev, hold, e;

    crb_buffer crb_buffer_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n),
        .i_width_select_strap(i_width_select_strap), .i_bank_select_strap(i_bank_select_strap),
        .i_data(i_data), .i_register_chip_select_n(i_register_chip_select_n),
        .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_out_ready(i_out_ready),
        .o_pin_a(o_pin_a), .o_pin_b(o_pin_b));
    crb_ctrl_model crb_ctrl_model_inst (.i_clk(i_clk), .i_in_ready(o_in_ready),
        .o_data(i_data), .o_csr_n(i_register_chip_select_n), .o_valid(i_in_valid));

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // next output state for a captured word
    function automatic crb_pins_t predict(input logic [CRB_DATA_W-1:0] d, input logic c);
        crb_pins_t n;
        logic [CRB_ROWS-1:0] m;
        n.a = d[13:0];
        n.b = i_width_select_strap ? d[13:0] : {d[24:18], 1'b0, d[17:16], 1'b0, d[15:14], 1'b0};
        m = (i_width_select_strap && i_bank_select_strap) ? 14'h2440 : 14'h0049;
        if (d[6] && c) begin
            n.a = (prev.a & ~m) | (n.a & m);
            n.b = (prev.b & ~m) | (n.b & m);
        end
        return n;
    endfunction

    // tie[1] set: register select held at tie[0], else random
    task automatic put(input logic [1:0] tie);
        logic [CRB_DATA_W-1:0] d;
        logic c;
        d = CRB_DATA_W'($urandom);
        c = tie[1] ? tie[0] : 1'($urandom);
        crb_ctrl_model_inst.send(d, c, ok);
        if (!ok) begin
            miscompares++;
        end else begin
            prev = predict(d, c);
            exp_q.push_back(prev);
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // watcher: one capture per edge with a held word and ready high
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            print_verdict();
        end
        p = cnt > 0 && i_out_ready;
        cnt = cnt + int'(i_in_valid && o_in_ready) - int'(p);
        if (i_sys_rst || !i_reset_n) begin
            cnt = 0;
            p = 1'b0;
            exp_q.delete();
        end
        if (p) begin
            #1;
            if (exp_q.size() == 0) begin
                miscompares++;
            end else begin
                e = exp_q.pop_front();
                `CHK({o_pin_a, o_pin_b}, e)
            end
        end
    end

    initial begin
        void'($urandom(32'h1821));
        i_sys_rst = 1'b1;
        i_reset_n = 1'b0;
        i_width_select_strap = 1'b0;
        i_bank_select_strap = 1'b0;
        i_out_ready = 1'b0;
        repeat (2) @(posedge i_clk);
        for (int md = 0; md < 3; md++) begin
            crb_ctrl_model_inst.junk();
            if (md == 2) begin
                @(negedge i_clk);
                i_sys_rst = 1'b1;
                repeat (2) @(negedge i_clk);
                `CHK({o_pin_a, o_pin_b}, 28'h0000000)
            end
            i_reset_n = 1'b0;
            #1 `CHK({o_pin_a, o_pin_b}, 28'h0000000)
            i_sys_rst = 1'b1;
            i_width_select_strap = md != 0;
            i_bank_select_strap = md == 2;
            repeat (3) @(posedge i_clk);
            `CHK({o_pin_a, o_pin_b}, 28'h0000000)
            prev = '0;
            crb_ctrl_model_inst.quiet();
            i_reset_n = 1'b1;
            i_sys_rst = 1'b0;
            repeat (3) @(negedge i_clk);
            `CHK({o_pin_a, o_pin_b}, 28'h0000000)
            i_out_ready = 1'b1;
            repeat (8) put(2'b00);
            repeat (4) put(2'b10);
            repeat (4) put(2'b11);
            crb_ctrl_model_inst.idle();
            @(negedge i_clk);
            i_out_ready = 1'b0;
            hold = prev;
            repeat (8) put(2'b00);
            crb_ctrl_model_inst.junk();
            @(negedge i_clk);
            `CHK(o_in_ready, 1'b0)
            `CHK({o_pin_a, o_pin_b}, hold)
            crb_ctrl_model_inst.idle();
            i_out_ready = 1'b1;
            repeat (12) @(negedge i_clk);
            `CHK(32'(exp_q.size()), 32'h0)
        end
        print_verdict();
    end
endmodule
